// >>> rtl/csp_pkg.sv
// Shared constants and types for the codec serial port front end.
// Assumes a single 100 MHz AHB-Lite clock that also serves as the master clock.
package csp_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CTRL_C = 8'h08;
  localparam logic [7:0] OFF_CTRL_D = 8'h0C;
  localparam logic [7:0] OFF_CTRL_E = 8'h10;
  localparam logic [7:0] OFF_TX_DATA = 8'h14;
  localparam logic [7:0] OFF_RX_DATA = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // Reset values of the control registers and the transmit data register
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h00;
  localparam logic [7:0] RST_CTRL_D = 8'h00;
  localparam logic [7:0] RST_CTRL_E = 8'h00;
  localparam logic [15:0] RST_TX_DATA = 16'h0000;

  // Field positions
  localparam int PRE_LSB = 0;   // ctrl_reg_b[2:0]: prescaler ratio minus one
  localparam int SDIV_LSB = 3;  // ctrl_reg_b[4:3]: serial divider ratio / 2 minus one
  localparam int GAIN_LSB = 0;  // ctrl_reg_d[2:0]: encoder gain code
  localparam int SRC_LSB = 0;   // ctrl_reg_c[3:0]: encoder input selection
  localparam int CW_IDX_LSB = 8;  // Control word: register index in bits 10:8

  // Timing counts: tick dividers in internal clock ticks, word length in bits
  localparam int SAMPLE_DIV = 256;
  localparam int ENC_DIV = 8;
  localparam int WORD_BITS = 16;

  typedef struct packed {
    logic se_sel;        // 1 selects the negative pin in single-ended mode
    logic single_ended;
    logic invert;
    logic loopback;      // analog loop-back from the decoder output
  } csp_enc_src_t;

  typedef struct packed {
    logic ctrl_flag;     // 1 marks a control word
    logic [14:0] sample;
  } csp_word_t;

endpackage : csp_pkg

// >>> rtl/csp_top.sv
// Codec serial port front end: AHB-Lite register file, clock division,
// sample timing and the 16-bit serial link with frame pulses.
// Assumes port pins are synchronous to hclk except port_enable, which is synchronised.
//
// How it works
// - Serial output bits change on the rising serial clock edge.
// - Serial output floats when idle or when the port is disabled.
// - Output frame pulse lasts one serial period before each word's MSB.
// - Input frame pulse precedes input MSB by one period, sampled on fall.
// - Serial input bits are captured on the falling serial clock edge.
// - Disabled port floats the serial data and frame pulse outputs and ignores serial inputs.
// - Disabled port stops the serial clock.
// - Control and data registers survive a disable and re-enable.
// - Re-enable restarts timing counters and shift state from reset.
// - Serial clock is master clock over prescaler times serial divider.
// - Internal master clock comes from a programmable prescaler.
// - Sample tick every 256 internal clock ticks.
// - Five eight-bit read/write control registers A to E.
// - Control register bits numbered 7 (MSB) down to 0 (LSB).
// - Encoder input selects pins or loop-back, optionally inverted.
// - Single-ended mode uses one analog pin chosen by software.
// - Encoder gain code lives in control register D bits 2 to 0.
// - Gain codes map to 0,6,12,18,20,26,32,38 dB.
// - Encoder sampling strobe every eight internal clock ticks.
// - Active-low reset clears control registers and all state.
// - Words are 16 bits: control flag MSB plus 15-bit sample.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps

module csp_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial port pins
  input wire logic port_enable,
  output logic sclk,
  output logic ser_data_out,
  output logic ser_data_out_oe,
  output logic out_frame_pulse,
  output logic out_frame_pulse_oe,
  input wire logic ser_data_in,
  input wire logic in_frame_pulse,
  // Converter side
  output logic internal_master_clk,
  output logic sample_tick,
  output logic enc_sample_tick,
  output logic [5:0] enc_gain_db,
  output csp_pkg::csp_enc_src_t enc_src
);

  function automatic logic [5:0] gain_db(input logic [2:0] code);
    logic [5:0] g;
    g = 6'h00;
    unique case (code)
      3'h0: g = 6'h00;
      3'h1: g = 6'h06;
      3'h2: g = 6'h0C;
      3'h3: g = 6'h12;
      3'h4: g = 6'h14;
      3'h5: g = 6'h1A;
      3'h6: g = 6'h20;
      3'h7: g = 6'h26;
    endcase
    return g;
  endfunction : gain_db

  typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_SHIFT} csp_tx_state_t;

  // Registers
  logic [7:0] ctrl_reg_a_r, ctrl_reg_b_r, ctrl_reg_c_r, ctrl_reg_d_r, ctrl_reg_e_r;
  logic [15:0] tx_data_r, rx_data_r;
  logic rx_new_r, rx_ovr_r;

  // Port enable synchroniser
  logic en_meta_r, en_sync_r;

  // Timing
  logic [2:0] pre_cnt_r;
  logic [7:0] samp_cnt_r;
  logic [1:0] half_cnt_r;
  logic dm_tick, sclk_r, sclk_rise, sclk_fall;

  // Transmit and receive
  csp_tx_state_t tx_state_r;
  logic tx_pend_r, rx_active_r, rx_done;
  logic [15:0] tx_shift_r, rx_shift_r;
  logic [4:0] tx_cnt_r, rx_cnt_r;
  csp_pkg::csp_word_t rx_word;

  // Bus
  logic wr_pend_r, addr_ok, rd_rx;
  logic [7:0] wr_addr_r;

  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_rx = addr_ok && !hwrite && (haddr[7:0] == csp_pkg::OFF_RX_DATA);

  // Two flops before any use so a mid-cycle edge cannot make a runt serial clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end else begin
      en_meta_r <= port_enable;
      en_sync_r <= en_meta_r;
    end
  end

  // Prescaler gives one internal tick every (field + 1) master clocks
  assign dm_tick = (pre_cnt_r == ctrl_reg_b_r[csp_pkg::PRE_LSB +: 3]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 3'h0;
    end else if (!en_sync_r || dm_tick) begin
      pre_cnt_r <= 3'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_cnt_r <= 8'h00;
      internal_master_clk <= 1'b0;
      sample_tick <= 1'b0;
      enc_sample_tick <= 1'b0;
    end else if (!en_sync_r) begin
      samp_cnt_r <= 8'h00;
      internal_master_clk <= 1'b0;
      sample_tick <= 1'b0;
      enc_sample_tick <= 1'b0;
    end else begin
      internal_master_clk <= dm_tick;
      sample_tick <= dm_tick && (samp_cnt_r == 8'(csp_pkg::SAMPLE_DIV - 1));
      enc_sample_tick <= dm_tick && (samp_cnt_r[2:0] == 3'(csp_pkg::ENC_DIV - 1));
      if (dm_tick) begin
        samp_cnt_r <= samp_cnt_r + 8'h01;
      end
    end
  end

  // Half period of the serial clock is (sdiv field + 1) internal ticks
  assign sclk_rise = dm_tick && !sclk_r && (half_cnt_r[1:0] == ctrl_reg_b_r[csp_pkg::SDIV_LSB +: 2]);
  assign sclk_fall = dm_tick && sclk_r && (half_cnt_r[1:0] == ctrl_reg_b_r[csp_pkg::SDIV_LSB +: 2]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_r <= 2'h0;
      sclk_r <= 1'b0;
    end else if (!en_sync_r) begin
      half_cnt_r <= 2'h0;
      sclk_r <= 1'b0;
    end else if (sclk_rise || sclk_fall) begin
      half_cnt_r <= 2'h0;
      sclk_r <= !sclk_r;
    end else if (dm_tick) begin
      half_cnt_r <= half_cnt_r + 2'h1;
    end
  end

  assign sclk = sclk_r;

  // Transmit: one sample tick queues a word; it starts on the next rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_r <= TX_IDLE;
      tx_pend_r <= 1'b0;
      tx_shift_r <= 16'h0000;
      tx_cnt_r <= 5'h00;
      ser_data_out <= 1'b0;
      ser_data_out_oe <= 1'b0;
      out_frame_pulse <= 1'b0;
      out_frame_pulse_oe <= 1'b0;
    end else if (!en_sync_r) begin
      tx_state_r <= TX_IDLE;
      tx_pend_r <= 1'b0;
      tx_cnt_r <= 5'h00;
      ser_data_out <= 1'b0;
      ser_data_out_oe <= 1'b0;
      out_frame_pulse <= 1'b0;
      out_frame_pulse_oe <= 1'b0;
    end else begin
      out_frame_pulse_oe <= 1'b1;
      if (sample_tick) begin
        tx_pend_r <= 1'b1;
      end
      if (sclk_rise) begin
        unique case (tx_state_r)
          TX_IDLE: begin
            ser_data_out_oe <= 1'b0;
            out_frame_pulse <= 1'b0;
            if (tx_pend_r) begin
              tx_pend_r <= sample_tick;
              tx_shift_r <= tx_data_r;
              out_frame_pulse <= 1'b1;
              tx_state_r <= TX_FRAME;
            end
          end
          TX_FRAME: begin
            out_frame_pulse <= 1'b0;
            ser_data_out <= tx_shift_r[15];
            ser_data_out_oe <= 1'b1;
            tx_shift_r <= {tx_shift_r[14:0], 1'b0};
            tx_cnt_r <= 5'(csp_pkg::WORD_BITS - 1);
            tx_state_r <= TX_SHIFT;
          end
          TX_SHIFT: begin
            if (tx_cnt_r == 5'h00) begin
              ser_data_out <= 1'b0;
              ser_data_out_oe <= 1'b0;
              tx_state_r <= TX_IDLE;
              if (tx_pend_r) begin
                tx_pend_r <= sample_tick;
                tx_shift_r <= tx_data_r;
                out_frame_pulse <= 1'b1;
                tx_state_r <= TX_FRAME;
              end
            end else begin
              ser_data_out <= tx_shift_r[15];
              tx_shift_r <= {tx_shift_r[14:0], 1'b0};
              tx_cnt_r <= tx_cnt_r - 5'h01;
            end
          end
        endcase
      end
    end
  end

  // Receive: frame pulse seen on a falling edge, then 16 bits on later falls
  assign rx_done = sclk_fall && rx_active_r && (rx_cnt_r == 5'h01);
  assign rx_word = {rx_shift_r[14:0], ser_data_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_active_r <= 1'b0;
      rx_shift_r <= 16'h0000;
      rx_cnt_r <= 5'h00;
    end else if (!en_sync_r) begin
      rx_active_r <= 1'b0;
      rx_cnt_r <= 5'h00;
    end else if (sclk_fall) begin
      if (rx_active_r) begin
        rx_shift_r <= {rx_shift_r[14:0], ser_data_in};
        rx_cnt_r <= rx_cnt_r - 5'h01;
        rx_active_r <= (rx_cnt_r != 5'h01);
      end else if (in_frame_pulse) begin
        rx_active_r <= 1'b1;
        rx_cnt_r <= 5'(csp_pkg::WORD_BITS);
      end
    end
  end

  // Data words land in the receive register; the new flag wins over a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_r <= 16'h0000;
      rx_new_r <= 1'b0;
      rx_ovr_r <= 1'b0;
    end else if (rx_done && !rx_word.ctrl_flag) begin
      rx_data_r <= rx_word;
      rx_new_r <= 1'b1;
      rx_ovr_r <= rx_ovr_r || (rx_new_r && !rd_rx);
    end else if (rd_rx) begin
      rx_new_r <= 1'b0;
      rx_ovr_r <= 1'b0;
    end
  end

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[7:0];
      end
    end
  end

  // Control registers: written by the bus or by a serial control word.
  // Port disable leaves them alone, only hresetn clears them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg_a_r <= csp_pkg::RST_CTRL_A;
      ctrl_reg_b_r <= csp_pkg::RST_CTRL_B;
      ctrl_reg_c_r <= csp_pkg::RST_CTRL_C;
      ctrl_reg_d_r <= csp_pkg::RST_CTRL_D;
      ctrl_reg_e_r <= csp_pkg::RST_CTRL_E;
      tx_data_r <= csp_pkg::RST_TX_DATA;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        csp_pkg::OFF_CTRL_A: ctrl_reg_a_r <= hwdata[7:0];
        csp_pkg::OFF_CTRL_B: ctrl_reg_b_r <= hwdata[7:0];
        csp_pkg::OFF_CTRL_C: ctrl_reg_c_r <= hwdata[7:0];
        csp_pkg::OFF_CTRL_D: ctrl_reg_d_r <= hwdata[7:0];
        csp_pkg::OFF_CTRL_E: ctrl_reg_e_r <= hwdata[7:0];
        csp_pkg::OFF_TX_DATA: tx_data_r <= hwdata[15:0];
        default: ;
      endcase
    end else if (rx_done && rx_word.ctrl_flag) begin
      unique case (rx_word[csp_pkg::CW_IDX_LSB +: 3])
        3'h0: ctrl_reg_a_r <= rx_word[7:0];
        3'h1: ctrl_reg_b_r <= rx_word[7:0];
        3'h2: ctrl_reg_c_r <= rx_word[7:0];
        3'h3: ctrl_reg_d_r <= rx_word[7:0];
        3'h4: ctrl_reg_e_r <= rx_word[7:0];
        default: ;
      endcase
    end
  end

  // Read data is registered at the address phase so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        unique case (haddr[7:0])
          csp_pkg::OFF_CTRL_A: hrdata <= {24'h000000, ctrl_reg_a_r};
          csp_pkg::OFF_CTRL_B: hrdata <= {24'h000000, ctrl_reg_b_r};
          csp_pkg::OFF_CTRL_C: hrdata <= {24'h000000, ctrl_reg_c_r};
          csp_pkg::OFF_CTRL_D: hrdata <= {24'h000000, ctrl_reg_d_r};
          csp_pkg::OFF_CTRL_E: hrdata <= {24'h000000, ctrl_reg_e_r};
          csp_pkg::OFF_TX_DATA: hrdata <= {16'h0000, tx_data_r};
          csp_pkg::OFF_RX_DATA: hrdata <= {16'h0000, rx_data_r};
          csp_pkg::OFF_STATUS: hrdata <= {28'h0000000, rx_ovr_r, rx_new_r,
                                          (tx_state_r != TX_IDLE), en_sync_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Encoder front-end controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_gain_db <= 6'h00;
      enc_src <= '0;
    end else begin
      enc_gain_db <= gain_db(ctrl_reg_d_r[csp_pkg::GAIN_LSB +: 3]);
      enc_src <= ctrl_reg_c_r[csp_pkg::SRC_LSB +: 4];
    end
  end

endmodule : csp_top

// >>> test/csp_top_sva.sv
// Checker for the serial pins and converter ticks of csp_top.
// Assumes it is bound to csp_top and sees only its ports.
`timescale 1ns/100ps
module csp_top_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial pins
  input wire logic port_enable,
  input wire logic sclk,
  input wire logic ser_data_out,
  input wire logic ser_data_out_oe,
  input wire logic out_frame_pulse,
  input wire logic out_frame_pulse_oe,
  // Converter ticks
  input wire logic internal_master_clk,
  input wire logic sample_tick,
  input wire logic enc_sample_tick
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic sclk_r, enc_ok_r, smp_ok_r;
  logic [4:0] bits_r;
  logic [3:0] enc_r;
  logic [8:0] smp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sclk_r <= 1'b0;
    else sclk_r <= sclk;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bits_r <= 5'h00;
    else if (!ser_data_out_oe) bits_r <= 5'h00;
    else if (sclk && !sclk_r) bits_r <= bits_r + 5'h01;
  end
  // Tick spacing is counted in internal ticks, so any prescaler setting is covered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_r <= 4'h0;
      smp_r <= 9'h000;
      enc_ok_r <= 1'b0;
      smp_ok_r <= 1'b0;
    end else begin
      enc_r <= enc_sample_tick ? 4'h0 : enc_r + {3'h0, internal_master_clk};
      smp_r <= sample_tick ? 9'h000 : smp_r + {8'h00, internal_master_clk};
      enc_ok_r <= port_enable && (enc_ok_r || enc_sample_tick);
      smp_ok_r <= port_enable && (smp_ok_r || sample_tick);
    end
  end
  a_sdo_on_rise: assert property (
    ser_data_out_oe && $past(ser_data_out_oe) && $changed(ser_data_out) |-> $rose(sclk))
    else $error("Serial data moved off a rising serial clock");
  a_oe_after_frame: assert property (
    $rose(ser_data_out_oe) |-> $past(out_frame_pulse) && $rose(sclk))
    else $error("Serial output driven without a frame pulse before it");
  a_frame_on_rise: assert property (
    $rose(out_frame_pulse) |-> $rose(sclk) && out_frame_pulse_oe)
    else $error("Frame pulse started off a rising serial clock");
  a_word_bits: assert property (
    $fell(ser_data_out_oe) && port_enable && $past(port_enable, 3) |-> bits_r == 5'h10)
    else $error("Output word was not sixteen bits long");
  a_off_float: assert property (
    !port_enable [*5] |-> !ser_data_out_oe && !out_frame_pulse_oe)
    else $error("Serial outputs driven while the port is disabled");
  a_off_sclk: assert property (
    !port_enable [*5] |-> !sclk)
    else $error("Serial clock running while the port is disabled");
  a_enc_rate: assert property (
    enc_sample_tick && enc_ok_r |-> enc_r + internal_master_clk == 8)
    else $error("Encoder strobe not every eight internal ticks");
  a_sample_rate: assert property (
    sample_tick && smp_ok_r |-> smp_r + internal_master_clk == 256)
    else $error("Sample tick not every 256 internal ticks");
  c_word: cover property ($rose(ser_data_out_oe));
  c_sample: cover property (sample_tick);
  c_off: cover property ($fell(port_enable));
endmodule : csp_top_sva

bind csp_top csp_top_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .port_enable(port_enable), .sclk(sclk),
  .ser_data_out(ser_data_out), .ser_data_out_oe(ser_data_out_oe),
  .out_frame_pulse(out_frame_pulse), .out_frame_pulse_oe(out_frame_pulse_oe),
  .internal_master_clk(internal_master_clk), .sample_tick(sample_tick),
  .enc_sample_tick(enc_sample_tick)
);

// >>> test/csp_host_model.sv
// Host serial port model: receives device words, sends host words on request.
// Assumes sclk is registered on hclk, so each serial edge is seen one hclk late.
`timescale 1ns/100ps
module csp_host_model (
  // Clock and device pins
  input wire logic hclk,
  input wire logic sclk,
  input wire logic ser_data_out,
  input wire logic out_frame_pulse,
  // Bench side
  input wire logic go,
  input wire logic frame_loopback_wiring,
  input wire logic [15:0] tx_word,
  output logic in_frame_pulse,
  output logic ser_data_in,
  output logic busy,
  output logic [15:0] rx_word,
  output logic [7:0] rx_cnt
);
  logic sclk_r = 1'b0, pend_r = 1'b0;
  logic [4:0] tcnt_r = 5'h00, rcnt_r = 5'h00;
  logic [15:0] tsh_r = 16'h0000, rsh_r = 16'h0000;
  initial begin
    in_frame_pulse = 1'b0;
    ser_data_in = 1'b0;
    rx_word = 16'h0000;
    rx_cnt = 8'h00;
  end
  assign busy = pend_r || in_frame_pulse || (tcnt_r != 5'h00);
  always @(posedge hclk) sclk_r <= sclk;
  // Launch just after the rise, well clear of the device's falling sample
  always @(posedge hclk) begin
    if (go) pend_r <= 1'b1;
    if (sclk && !sclk_r) begin
      in_frame_pulse <= 1'b0;
      if (tcnt_r != 5'h00) begin
        ser_data_in <= tsh_r[15];
        tsh_r <= {tsh_r[14:0], 1'b0};
        tcnt_r <= tcnt_r - 5'h01;
      end else begin
        // Idle line toggles, so a stale sample never passes for data
        ser_data_in <= ~ser_data_in;
        // Loop-back: the device's own frame pulse starts every host word
        if ((pend_r || go || frame_loopback_wiring) && (!frame_loopback_wiring || out_frame_pulse)) begin
          in_frame_pulse <= !frame_loopback_wiring;
          tsh_r <= tx_word;
          tcnt_r <= 5'h10;
          pend_r <= 1'b0;
        end
      end
    end
  end
  always @(posedge hclk) begin
    if (!sclk && sclk_r) begin
      if (rcnt_r != 5'h00) begin
        rsh_r <= {rsh_r[14:0], ser_data_out};
        rcnt_r <= rcnt_r - 5'h01;
      end else if (out_frame_pulse) rcnt_r <= 5'h10;
      if (rcnt_r == 5'h01) begin
        rx_word <= {rsh_r[14:0], ser_data_out};
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule : csp_host_model

// >>> test/tb.sv
// Self-checking bench for csp_top with a host serial port model.
// Assumes the package, csp_top, its checker and the host model compile first.
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] OFFS [5] = '{csp_pkg::OFF_CTRL_A, csp_pkg::OFF_CTRL_B,
    csp_pkg::OFF_CTRL_C, csp_pkg::OFF_CTRL_D, csp_pkg::OFF_CTRL_E};
  localparam logic [7:0] VALS [5] = '{8'h5A, 8'h18, 8'h0A, 8'h3C, 8'hC3};
  localparam logic [5:0] DB [8] = '{6'h00, 6'h06, 6'h0C, 6'h12, 6'h14, 6'h1A, 6'h20, 6'h26};
  localparam logic [15:0] TXV [2] = '{16'h1234, 16'h6DB5};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, port_enable = 1'b1;
  logic go = 1'b0, frame_loopback_wiring = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] tx_word = 16'h0000, rx_word;
  logic [7:0] rx_cnt;
  logic [5:0] enc_gain_db;
  logic hreadyout, hresp, sclk, ser_data_out, ser_data_out_oe, out_frame_pulse;
  logic out_frame_pulse_oe, ser_data_in, in_frame_pulse, internal_master_clk, busy;
  logic sample_tick, enc_sample_tick;
  csp_pkg::csp_enc_src_t enc_src;
  int mismatches = 0, check_count = 0;
  always #5 hclk = ~hclk;
  csp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_enable(port_enable),
    .sclk(sclk), .ser_data_out(ser_data_out), .ser_data_out_oe(ser_data_out_oe),
    .out_frame_pulse(out_frame_pulse), .out_frame_pulse_oe(out_frame_pulse_oe),
    .ser_data_in(ser_data_in), .in_frame_pulse(frame_loopback_wiring ? out_frame_pulse : in_frame_pulse),
    .internal_master_clk(internal_master_clk), .sample_tick(sample_tick),
    .enc_sample_tick(enc_sample_tick), .enc_gain_db(enc_gain_db), .enc_src(enc_src));
  // Floated pins reach the host as z, so a word that loses its drive mismatches
  csp_host_model u_host (.hclk(hclk), .sclk(sclk), .go(go), .frame_loopback_wiring(frame_loopback_wiring), .tx_word(tx_word),
    .ser_data_out(ser_data_out_oe ? ser_data_out : 1'bz), .busy(busy),
    .out_frame_pulse(out_frame_pulse_oe ? out_frame_pulse : 1'bz),
    .in_frame_pulse(in_frame_pulse), .ser_data_in(ser_data_in),
    .rx_word(rx_word), .rx_cnt(rx_cnt));
  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(inout int n);
    @(posedge hclk);
    n++;
    if (n > 3000) begin
      mismatches++;
      $display("BAD wait expected done seen timeout");
      test_done();
    end
  endtask : step
  task automatic rdy();
    int n = 0;
    do step(n); while (hreadyout !== 1'b1);
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("rdata", {16'h0, exp}, {16'h0, q[15:0]});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge hclk);
  endtask : wr
  task automatic wait_rx();
    logic [7:0] c0 = rx_cnt;
    int n = 0;
    do step(n); while (rx_cnt === c0);
  endtask : wait_rx
  task automatic gap(input logic use_sclk, output int n);
    logic p, c, hit;
    int k = 0;
    p = 1'b1;
    for (int r = 0; r < 2; r++) begin
      n = 0;
      do begin
        step(k);
        n++;
        c = use_sclk ? sclk : internal_master_clk;
        hit = use_sclk ? (c && !p) : c;
        p = c;
      end while (hit !== 1'b1);
    end
  endtask : gap
  task automatic send(input logic [15:0] w);
    int n = 0;
    tx_word <= w;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do step(n); while (busy !== 1'b0);
    repeat (50) @(posedge hclk);
  endtask : send
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(OFFS[i], 16'h0000);
    chk("gain", 32'h0, {26'h0, enc_gain_db});
    chk("src", 32'h0, {28'h0, enc_src});
    for (int i = 0; i < 5; i++) wr(OFFS[i], {24'hFFFFFF, VALS[i]});
    for (int i = 0; i < 5; i++) rd(OFFS[i], {8'h00, VALS[i]});
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 16'h0000);
  endtask : t_regs
  task automatic t_clk();
    int n;
    wr(OFFS[1], 32'h1A);
    gap(1'b1, n);
    chk("sclk_period", 32'h18, n);
    gap(1'b0, n);
    chk("imc_period", 32'h3, n);
    wr(OFFS[1], 32'h18);
    gap(1'b1, n);
    chk("sclk_period", 32'h8, n);
  endtask : t_clk
  task automatic t_enc();
    for (int i = 0; i < 8; i++) begin
      wr(OFFS[3], 32'hA8 | i);
      chk("gain", {26'h0, DB[i]}, {26'h0, enc_gain_db});
    end
    wr(OFFS[2], 32'hF5);
    chk("src", 32'h5, {28'h0, enc_src});
    wr(OFFS[2], 32'h0A);
    chk("src", 32'hA, {28'h0, enc_src});
  endtask : t_enc
  task automatic t_link();
    for (int i = 0; i < 2; i++) begin
      wr(csp_pkg::OFF_TX_DATA, {16'h0, TXV[i]});
      wait_rx();
      wait_rx();
      chk("rx_word", {16'h0, TXV[i]}, {16'h0, rx_word});
    end
    send(16'h2A5C);
    rd(csp_pkg::OFF_RX_DATA, 16'h2A5C);
    send(16'h8314);
    rd(OFFS[3], 16'h0014);
    chk("gain", 32'h14, {26'h0, enc_gain_db});
  endtask : t_link
  task automatic t_off();
    int n;
    port_enable <= 1'b0;
    repeat (20) @(posedge hclk);
    chk("sdo_oe", 32'h0, {31'h0, ser_data_out_oe});
    chk("ofp_oe", 32'h0, {31'h0, out_frame_pulse_oe});
    chk("sclk", 32'h0, {31'h0, sclk});
    repeat (600) @(posedge hclk);
    rd(csp_pkg::OFF_STATUS, 16'h0000);
    port_enable <= 1'b1;
    rd(OFFS[0], 16'h005A);
    rd(csp_pkg::OFF_RX_DATA, 16'h2A5C);
    gap(1'b1, n);
    chk("sclk_period", 32'h8, n);
    // A frame cut by the disable may still end as junk at the host
    wait_rx();
    wait_rx();
    chk("rx_word", 32'h6DB5, {16'h0, rx_word});
  endtask : t_off
  // Switch wiring only just after a word, far from the next frame pulse
  task automatic t_frame_loopback_wiring();
    wait_rx();
    tx_word <= 16'h1357;
    frame_loopback_wiring <= 1'b1;
    wait_rx();
    wait_rx();
    frame_loopback_wiring <= 1'b0;
    rd(csp_pkg::OFF_RX_DATA, 16'h1357);
    chk("rx_word", 32'h6DB5, {16'h0, rx_word});
  endtask : t_frame_loopback_wiring
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_clk();
    t_enc();
    t_link();
    t_off();
    t_frame_loopback_wiring();
    test_done();
  end
endmodule : tb
